// ===== common/itk_pkg.sv
// constants shared by the interval timekeeper design files
`default_nettype none
package itk_pkg;
  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hA1;
  localparam logic [7:0] IDX_FRACTION = 8'hA2;
  localparam logic [7:0] IDX_ONE_HZ = 8'hA3;
  localparam logic [7:0] IDX_MINUTE = 8'hA4;
  localparam logic [7:0] IDX_HOUR = 8'hA5;
  localparam logic [7:0] IDX_TARGET = 8'hA6;
  localparam logic [7:0] IDX_IRQ_EN = 8'hA7;
  localparam int ADR_W = 10;

  // ----------------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------------
  localparam int BIT_UNUSED = 7;
  localparam int BIT_DAY_WRAP = 6;
  localparam int BIT_BASE_HI = 5;
  localparam int BIT_BASE_LO = 4;
  localparam int BIT_ONE_SHOT = 3;
  localparam int BIT_MATCH = 2;
  localparam int BIT_IV_EN = 1;
  localparam int BIT_TK_EN = 0;
  localparam int BIT_IRQ_EN = 0;

  // ----------------------------------------------------------------------
  // reset values and counter limits
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] MAX_FRACTION = 8'h7F;
  localparam logic [7:0] MAX_SIXTY = 8'h3B;
  localparam logic [7:0] MAX_HOUR_24 = 8'h17;
  localparam logic [7:0] MAX_HOUR_256 = 8'hFF;
  localparam int STAGES = 4;

  // ----------------------------------------------------------------------
  // timing: crystal edges per 1/128 second tick
  // ----------------------------------------------------------------------
  localparam int XTAL_HZ = 32768;
  localparam int TICK_HZ = 128;
  localparam int XTAL_PER_TICK = XTAL_HZ / TICK_HZ;
endpackage : itk_pkg
`default_nettype wire

// ===== rtl/itk_interval_timekeeper.sv
// time counter chain and interval counter with a classic wishbone slave
`timescale 1ns/10ps
`default_nettype none
module itk_interval_timekeeper #(
  parameter int XTAL_DIV = itk_pkg::XTAL_PER_TICK
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [itk_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // crystal pin and interrupt request
  input wire logic xtal_clk_i,
  output logic irq_o
);
  import itk_pkg::*;

  localparam int PW = (XTAL_DIV > 1) ? $clog2(XTAL_DIV) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(XTAL_DIV - 1);

  if (XTAL_DIV < 2) begin : g_bad_div
    $error("itk: crystal divider must be at least 2");
  end

  // ----------------------------------------------------------------------
  // bus access
  // ----------------------------------------------------------------------
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  wire [7:0] idx = wb_adr_i[ADR_W-1:2];
  wire req = wb_cyc_i & wb_stb_i;
  // writes land on the edge at which the master sees ack
  wire wr_go = req & wb_we_i & ack_r & wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire wr_ctl = wr_go & (idx == IDX_CONTROL);
  wire wr_tgt = wr_go & (idx == IDX_TARGET);
  wire wr_ie = wr_go & (idx == IDX_IRQ_EN);

  assign ack_nxt = req & ~ack_r;

  // ----------------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------------
  logic day_wrap_r;
  logic [1:0] base_sel_r;
  logic one_shot_r;
  logic match_r;
  logic match_nxt;
  logic iv_en_r;
  logic iv_en_nxt;
  logic tk_en_r;
  logic irq_en_r;
  logic irq_r;
  logic [7:0] target_r;
  logic [7:0] ivc_r;
  logic [7:0] ivc_nxt;

  // ----------------------------------------------------------------------
  // crystal synchroniser and prescaler
  // ----------------------------------------------------------------------
  logic xt_s1_r;
  logic xt_s2_r;
  logic xt_s3_r;
  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  // core clock is far faster than the crystal, so edges are never missed
  wire xt_rise = xt_s2_r & ~xt_s3_r;
  wire pre_ovf = tk_en_r & xt_rise & (pre_r == PRE_LAST);
  assign pre_nxt = !tk_en_r ? '0 :
                   pre_ovf ? '0 :
                   xt_rise ? PW'(pre_r + 1'b1) : pre_r;

  // ----------------------------------------------------------------------
  // time counter chain
  // ----------------------------------------------------------------------
  logic [7:0] preset_r [STAGES];
  logic [7:0] live [STAGES];
  logic [7:0] wmax [STAGES];
  logic [STAGES:0] step;
  logic [STAGES-1:0] carry;
  logic [7:0] stage_idx [STAGES];

  assign step[0] = pre_ovf;
  assign stage_idx[0] = IDX_FRACTION;
  assign stage_idx[1] = IDX_ONE_HZ;
  assign stage_idx[2] = IDX_MINUTE;
  assign stage_idx[3] = IDX_HOUR;
  assign wmax[0] = MAX_FRACTION;
  assign wmax[1] = MAX_SIXTY;
  assign wmax[2] = MAX_SIXTY;
  assign wmax[3] = day_wrap_r ? MAX_HOUR_24 : MAX_HOUR_256;

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      // presets are written any time; they reach the live count only
      // while timekeeping is stopped, so a running clock never jumps
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          preset_r[g] <= RST_BYTE;
        end else if (wr_go && idx == stage_idx[g]) begin
          preset_r[g] <= wbyte;
        end
      end

      itk_wrap_cnt #(.W(8)) u_cnt (
        .clk(clk),
        .reset_n(reset_n),
        .run(tk_en_r),
        .inc(step[g]),
        .load_val(preset_r[g]),
        .wrap_max(wmax[g]),
        .cnt(live[g]),
        .carry(carry[g])
      );
      assign step[g+1] = carry[g];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // interval counter
  // ----------------------------------------------------------------------
  wire base_p = step[base_sel_r];
  wire iv_step = base_p & iv_en_r;
  wire [7:0] iv_inc = 8'(ivc_r + 1'b1);
  wire iv_hit = iv_step & (iv_inc == target_r);
  wire clr_match = wr_ctl & ~wbyte[BIT_MATCH];

  // the set wins over a software clear in the same cycle
  assign match_nxt = iv_hit | (match_r & ~clr_match);
  // a software write to the control byte outranks a one-shot timeout
  assign iv_en_nxt = wr_ctl ? wbyte[BIT_IV_EN] :
                     (iv_hit & one_shot_r) ? 1'b0 : iv_en_r;
  assign ivc_nxt = !iv_en_r ? RST_BYTE :
                   iv_hit ? RST_BYTE :
                   iv_step ? iv_inc : ivc_r;

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  wire [7:0] ctl_byte = {1'b0, day_wrap_r, base_sel_r, one_shot_r,
                         match_r, iv_en_r, tk_en_r};
  wire [7:0] rd_byte = (idx == IDX_CONTROL) ? ctl_byte :
                       (idx == IDX_FRACTION) ? live[0] :
                       (idx == IDX_ONE_HZ) ? live[1] :
                       (idx == IDX_MINUTE) ? live[2] :
                       (idx == IDX_HOUR) ? live[3] :
                       (idx == IDX_TARGET) ? target_r :
                       (idx == IDX_IRQ_EN) ? {7'h00, irq_en_r} : 8'h00;
  assign dat_nxt = ack_nxt ? {24'h000000, rd_byte} : 32'h00000000;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xt_s1_r <= 1'b0;
      xt_s2_r <= 1'b0;
      xt_s3_r <= 1'b0;
      pre_r <= '0;
    end else begin
      xt_s1_r <= xtal_clk_i;
      xt_s2_r <= xt_s1_r;
      xt_s3_r <= xt_s2_r;
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      day_wrap_r <= 1'b0;
      base_sel_r <= 2'h0;
      one_shot_r <= 1'b0;
      tk_en_r <= 1'b0;
    end else if (wr_ctl) begin
      day_wrap_r <= wbyte[BIT_DAY_WRAP];
      base_sel_r <= wbyte[BIT_BASE_HI:BIT_BASE_LO];
      one_shot_r <= wbyte[BIT_ONE_SHOT];
      tk_en_r <= wbyte[BIT_TK_EN];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      match_r <= 1'b0;
      iv_en_r <= 1'b0;
      ivc_r <= RST_BYTE;
      irq_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
      iv_en_r <= iv_en_nxt;
      ivc_r <= ivc_nxt;
      irq_r <= match_r & irq_en_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      target_r <= RST_BYTE;
      irq_en_r <= 1'b0;
    end else begin
      if (wr_tgt) target_r <= wbyte;
      if (wr_ie) irq_en_r <= wbyte[BIT_IRQ_EN];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_ack_single: assert property (@(posedge clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_unused_bit: assert property (@(posedge clk) disable iff (!reset_n)
    (wb_ack_o && idx == IDX_CONTROL && !wb_we_i) |-> !wb_dat_o[BIT_UNUSED])
    else $error("control bit 7 read back non-zero");

  a_match_sets: assert property (@(posedge clk) disable iff (!reset_n)
    (iv_step && iv_inc == target_r) |=> match_r)
    else $error("match flag not set on interval match");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(match_r) |-> $past(clr_match))
    else $error("match flag cleared without software write");

  a_oneshot_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (iv_hit && one_shot_r && !wr_ctl) |=> !iv_en_r)
    else $error("one-shot timeout left interval counting enabled");

  a_auto_reload: assert property (@(posedge clk) disable iff (!reset_n)
    (iv_hit && !one_shot_r && !wr_ctl) |=> (iv_en_r && ivc_r == 8'h00))
    else $error("auto-reload did not restart the interval counter");

  a_iv_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (!iv_en_r) |=> (ivc_r == 8'h00 && !$rose(match_r)))
    else $error("interval counter moved while disabled");

  a_fraction_wrap: assert property (@(posedge clk)
    disable iff (!reset_n)
    (step[0] && live[0] == MAX_FRACTION && tk_en_r)
      |=> (live[0] == 8'h00 && (live[1] == $past(live[1]) + 8'h01
           || ($past(live[1]) == MAX_SIXTY && live[1] == 8'h00))))
    else $error("fraction tick did not wrap into seconds");

  a_hour_24: assert property (@(posedge clk) disable iff (!reset_n)
    (step[3] && day_wrap_r && live[3] == MAX_HOUR_24 && tk_en_r)
      |=> live[3] == 8'h00)
    else $error("hour counter missed wrap after 23");

  a_stop_restore: assert property (@(posedge clk)
    disable iff (!reset_n)
    (!tk_en_r && !wr_go)
      |=> (live[1] == preset_r[1] && live[3] == preset_r[3]))
    else $error("stopped time counter does not show its preset");

  a_irq_follow: assert property (@(posedge clk) disable iff (!reset_n)
    (match_r && irq_en_r) |=> irq_o)
    else $error("interrupt not requested on enabled match");

  a_tick_rate: assert property (@(posedge clk) disable iff (!reset_n)
    step[0] |-> (tk_en_r && xt_rise))
    else $error("fraction tick not paced by crystal edge");
endmodule // itk_interval_timekeeper
`default_nettype wire

// ===== rtl/itk_wrap_cnt.sv
// one wrapping time counter stage that reloads a preset while stopped
`timescale 1ns/10ps
`default_nettype none
module itk_wrap_cnt #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic inc,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] wrap_max,
  // state
  output logic [W-1:0] cnt,
  output logic carry
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  if (W < 1) begin : g_bad_width
    $error("itk_wrap_cnt: width must be positive");
  end

  assign carry = run & inc & (cnt_r == wrap_max);
  assign cnt_nxt = !run ? load_val :
                   carry ? '0 :
                   inc ? W'(cnt_r + 1'b1) : cnt_r;
  assign cnt = cnt_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // itk_wrap_cnt
`default_nettype wire

// ===== tb/itk_interval_timekeeper_test.sv
// self-checking bench for the interval timekeeper
`timescale 1ns/10ps
`default_nettype none
module itk_interval_timekeeper_test;
  import itk_pkg::*;
  // ------------------------------------------------------------------
  // stimulus and observation signals
  // ------------------------------------------------------------------
  localparam int TICK = 16; // two crystal rises of eight clk each
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] dat_o;
  logic ack;
  logic xtal = 1'b0;
  logic irq_o;
  logic [2:0] xdiv = 3'h0;
  int n_errors = 0;
  int check_count = 0;
  int k;
  int n;
  int unsigned rs;
  logic [7:0] rd;
  logic [7:0] f;
  logic [7:0] s;
  logic [7:0] m;
  logic [7:0] h;
  logic [7:0] tg;
  logic wrp;

  itk_interval_timekeeper #(.XTAL_DIV(2)) u_itk_interval_timekeeper (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .xtal_clk_i(xtal), .irq_o(irq_o)
  );

  always #5 clk = ~clk;
  // crystal half period of four clk keeps the synchroniser comfortable
  always @(posedge clk) begin
    xdiv <= (xdiv == 3'h3) ? 3'h0 : xdiv + 3'h1;
    if (xdiv == 3'h3) begin
      xtal <= ~xtal;
    end
  end

  // ------------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic hang(input string what);
    n_errors++;
    $display("wrong value %s expected response seen none", what);
    tally_and_finish();
  endtask

  // ------------------------------------------------------------------
  // bus cycles and waits
  // ------------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] wd);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, wd};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = dat_o[7:0];
    chk("upper read data", {7'h00, |dat_o[31:8]}, 8'h00);
    if (i == 20) hang("bus ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string what, input logic [7:0] idx,
                     input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(what, rd, exp);
  endtask

  task automatic preset(input logic [7:0] pf, ps, pm, ph);
    wb(1'b1, IDX_FRACTION, pf);
    wb(1'b1, IDX_ONE_HZ, ps);
    wb(1'b1, IDX_MINUTE, pm);
    wb(1'b1, IDX_HOUR, ph);
  endtask

  task automatic wait_frac(input logic [7:0] old);
    for (int i = 0; i < 40; i++) begin
      wb(1'b0, IDX_FRACTION, 8'h00);
      if (rd !== old) return;
    end
    hang("fraction step");
  endtask

  task automatic wait_irq(output int cnt);
    for (cnt = 0; cnt < 3000; cnt++) begin
      @(posedge clk);
      if (irq_o === 1'b1) return;
    end
    hang("interrupt");
  endtask

  // ------------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------------
  function automatic logic [7:0] next_hour(input logic [7:0] hv,
                                           input logic w24);
    return (w24 && hv == 8'h17) ? 8'h00 : hv + 8'h01;
  endfunction

  function automatic int base_ticks(input int b);
    return (b == 0) ? 1 : (b == 1) ? 4 : 132;
  endfunction

  // start phase against the crystal is unknown, so allow a tick either way
  function automatic logic [7:0] in_win(input int cnt, input int t);
    return (cnt >= (t - 1) * TICK && cnt <= (t + 1) * TICK) ? 8'h01 : 8'h00;
  endfunction

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rs = $urandom(50);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 8; k++) begin
      rdc("reset value", (k == 7) ? 8'h10 : 8'hA1 + 8'(k), 8'h00);
    end
    wb(1'b1, 8'h10, 8'h5A);
    rdc("unmapped", 8'h10, 8'h00);
    // a write without the low byte lane enabled must be dropped
    sel <= 4'hE;
    wb(1'b1, IDX_TARGET, 8'h5A);
    sel <= 4'hF;
    rdc("masked write", IDX_TARGET, 8'h00);
    wb(1'b1, IDX_CONTROL, 8'hFC);
    rdc("control bits", IDX_CONTROL, 8'h78);
    wb(1'b1, IDX_CONTROL, 8'h00);
    f = 8'($urandom_range(126));
    s = 8'($urandom_range(59));
    m = 8'($urandom_range(59));
    h = 8'($urandom_range(23));
    preset(f, s, m, h);
    rdc("fraction preset", IDX_FRACTION, f);
    rdc("second preset", IDX_ONE_HZ, s);
    rdc("minute preset", IDX_MINUTE, m);
    rdc("hour preset", IDX_HOUR, h);
    wb(1'b1, IDX_CONTROL, 8'h41);
    wait_frac(f);
    chk("fraction step", rd, f + 8'h01);
    wb(1'b1, IDX_CONTROL, 8'h40);
    rdc("fraction restore", IDX_FRACTION, f);
    rdc("hour restore", IDX_HOUR, h);
    for (k = 0; k < 3; k++) begin
      h = (k == 2) ? 8'hFF : 8'h17;
      wrp = (k == 0);
      preset(8'h7F, 8'h3B, 8'h3B, h);
      wb(1'b1, IDX_CONTROL, {1'b0, wrp, 6'h01});
      wait_frac(8'h7F);
      chk("fraction wrap", rd, 8'h00);
      rdc("second wrap", IDX_ONE_HZ, 8'h00);
      rdc("minute wrap", IDX_MINUTE, 8'h00);
      rdc("hour step", IDX_HOUR, next_hour(h, wrp));
      wb(1'b1, IDX_CONTROL, 8'h00);
    end
    wb(1'b1, IDX_IRQ_EN, 8'h01);
    for (k = 0; k < 4; k++) begin
      preset(8'h7C, (k >= 2) ? 8'h3A : 8'h00, (k == 3) ? 8'h3B : 8'h00,
             8'h00);
      wb(1'b1, IDX_TARGET, 8'h01);
      wb(1'b1, IDX_CONTROL, {2'b01, 2'(k), 4'h3});
      wait_irq(n);
      chk("base timing", in_win(n, base_ticks(k)), 8'h01);
      rdc("match set", IDX_CONTROL, {2'b01, 2'(k), 4'h7});
      wb(1'b1, IDX_CONTROL, 8'h00);
    end
    tg = 8'($urandom_range(5, 2));
    wb(1'b1, IDX_TARGET, tg);
    wb(1'b1, IDX_CONTROL, 8'h4B);
    wait_irq(n);
    chk("one shot timing", in_win(n, int'(tg)), 8'h01);
    rdc("one shot stop", IDX_CONTROL, 8'h4D);
    repeat (5 * TICK) @(posedge clk);
    rdc("flag held", IDX_CONTROL, 8'h4D);
    wb(1'b1, IDX_IRQ_EN, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", {7'h00, irq_o}, 8'h00);
    wb(1'b1, IDX_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq enabled", {7'h00, irq_o}, 8'h01);
    wb(1'b1, IDX_CONTROL, 8'h49);
    rdc("flag cleared", IDX_CONTROL, 8'h49);
    repeat (2) @(posedge clk);
    chk("irq cleared", {7'h00, irq_o}, 8'h00);
    wb(1'b1, IDX_CONTROL, 8'h43);
    wait_irq(n);
    wb(1'b1, IDX_CONTROL, 8'h43);
    wait_irq(n);
    chk("reload timing", in_win(n, int'(tg)), 8'h01);
    wb(1'b1, IDX_CONTROL, 8'h00);
    tally_and_finish();
  end
endmodule // itk_interval_timekeeper_test
`default_nettype wire
